// ===== core/ccpu_unit.sv
// Capture/compare/PWM unit with AXI4-Lite register slave
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns

// Notes on behaviour
// - PWM timing follows the system clock; no private clock source.
// - Any reset returns all registers to reset state; pin becomes input.
// - Control bit 7 enables the unit; resets to 0; bit 6 reads 0.
// - Control bit 5 reads current output level; writes ignored.
// - Control bit 4 selects PWM alignment; unused outside PWM.
// - Low four control bits select mode; 1111 PWM; 1100-1110 reserved.
// - Mode 0000 switches everything off and holds the unit reset.
// - Modes 1011/1010 pulse output on match; 1011 also clears timer.
// - Mode 1001 drives output low on match; 1000 drives it high.
// - Modes 0010/0001 toggle on match; 0001 also clears timer.
// - Mode 0111 captures every 16th rising edge; 0110 every 4th.
// - Modes 0101 rising, 0100 falling, 0011 both edges capture.
// - Every event sets the event flag and may trigger a conversion.
// - Three-bit source field picks the capture input; 111 reserved.
// - Capture loads timer low and high bytes into value registers.
// - Compare matches when all sixteen timer bits equal the values.
// - Right-aligned PWM: low byte is width 7:0, high 1:0 is 9:8.
// - Left-aligned PWM: high byte is width 9:2, low 7:6 is 1:0.
// - Period end clears period timer, sets output unless zero, latches duty.
// - Output goes low when ten-bit time base equals buffered width.
// - With clock enable low, all state and pin drive hold.
module ccpu_unit
   import ccpu_pkg::*;
#(
   parameter int PWM_BITS = 10
)
(
   // Clock, reset, enable
   input  wire logic          mclk,
   input  wire logic          rst_n,
   input  wire logic          clk_en,
   // AXI4-Lite write
   input  wire logic [3:0]    s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   output logic [1:0]         s_axi_bresp,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   // AXI4-Lite read
   input  wire logic [3:0]    s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready,
   // Partner signals
   input  wire ccpu_sources_s sources,
   input  wire ccpu_timers_s  timers,
   // Unit outputs
   output logic               pin_out,
   output logic               pin_oe_n,
   output logic               timer_clear,
   output logic               period_timer_clear,
   output logic               unit_event_flag,
   output logic               conversion_trigger
);

   // Register state
   logic                unit_enable, next_unit_enable;
   logic                width_alignment, next_width_alignment;
   logic [3:0]          mode_select, next_mode_select;
   logic [2:0]          capture_source, next_capture_source;
   logic [7:0]          value_low_byte, next_value_low_byte;
   logic [7:0]          value_high_byte, next_value_high_byte;
   // Engine state
   logic                output_level, next_output_level;
   logic                pulse_pending, next_pulse_pending;
   logic                cap_prev, next_cap_prev;
   logic [3:0]          prescale, next_prescale;
   logic [PWM_BITS-1:0] duty_buffer, next_duty_buffer;
   logic                event_now;
   logic                cap_in;
   logic                cap_event;
   logic                match;
   logic                active;
   logic                is_capture, is_compare, is_pwm;
   logic [PWM_BITS-1:0] width_word;
   logic [PWM_BITS-1:0] time_base;
   logic                period_end;
   // Bus state
   ccpu_wr_e            wr_state, next_wr_state;
   logic                rd_valid, next_rd_valid;
   logic [31:0]         rd_data, next_rd_data;
   logic [1:0]          rd_resp, next_rd_resp;
   logic [1:0]          wr_resp, next_wr_resp;
   logic                wr_go;
   logic                rd_go;
   logic [7:0]          control_view;

   // Bit 5 shows live output level
   always_comb
   begin
      control_view = {unit_enable, 1'b0, output_level, width_alignment, mode_select};
   end

   // Mode decode; reserved codes fall in no class
   always_comb
   begin
      active     = unit_enable && (mode_select != MODE_OFF);
      is_pwm     = active && (mode_select == MODE_PWM);
      is_capture = active && (mode_select >= MODE_CAP_BOTH)
                   && (mode_select <= MODE_CAP_RISE16)
                   && (capture_source != SOURCE_RESERVED);
      is_compare = active && ((mode_select == MODE_TOGGLE_CLR)
                   || (mode_select == MODE_TOGGLE)
                   || ((mode_select >= MODE_CMP_SET)
                   && (mode_select <= MODE_CMP_PULSE_CL)));
   end

   always_comb
   begin
      case (capture_source)
         3'h0:    cap_in = sources.mapped_input_pin;
         3'h1:    cap_in = sources.comparator_one_output;
         3'h2:    cap_in = sources.comparator_two_output;
         3'h3:    cap_in = sources.oscillator_output;
         3'h4:    cap_in = sources.pin_change_event;
         3'h5:    cap_in = sources.logic_cell_one_out;
         3'h6:    cap_in = sources.logic_cell_two_out;
         default: cap_in = 1'b0;
      endcase
   end

   // Alignment bit only matters here, in PWM
   always_comb
   begin
      if (width_alignment)
         width_word = {value_high_byte, value_low_byte[7:6]};
      else
         width_word = {value_high_byte[1:0], value_low_byte};
      time_base  = {timers.period_timer, timers.time_base_low};
      period_end = timers.period_increment
                   && (timers.period_timer == timers.period_register);
   end

   // Capture edge and compare match detection
   always_comb
   begin
      next_cap_prev = cap_in;
      next_prescale = prescale;
      cap_event     = 1'b0;
      case (mode_select)
         MODE_CAP_BOTH:   cap_event = cap_in != cap_prev;
         MODE_CAP_FALL:   cap_event = cap_prev && !cap_in;
         MODE_CAP_RISE:   cap_event = !cap_prev && cap_in;
         MODE_CAP_RISE4,
         MODE_CAP_RISE16:
         begin
            if (!cap_prev && cap_in)
            begin
               if (prescale == ((mode_select == MODE_CAP_RISE4) ?
                                PRESCALE_4_LAST : PRESCALE_16_LAST))
               begin
                  cap_event     = 1'b1;
                  next_prescale = 4'h0;
               end
               else
                  next_prescale = prescale + 4'h1;
            end
         end
         default: cap_event = 1'b0;
      endcase
      cap_event = cap_event && is_capture;
      if (!is_capture)
         next_prescale = 4'h0;
      match = is_compare
              && (timers.sixteen_bit_timer == {value_high_byte, value_low_byte});
   end

   // Output engine
   always_comb
   begin
      next_output_level  = output_level;
      next_pulse_pending = 1'b0;
      next_duty_buffer   = duty_buffer;
      timer_clear        = 1'b0;
      period_timer_clear = 1'b0;
      event_now          = cap_event;
      if (!active)
      begin
         // Off or disabled holds the output low
         next_output_level = 1'b0;
         next_duty_buffer  = '0;
      end
      else if (is_pwm)
      begin
         if (period_end)
         begin
            period_timer_clear = 1'b1;
            next_duty_buffer   = width_word;
            next_output_level  = (width_word != '0);
            event_now          = 1'b1;
         end
         // Time base match ends the pulse
         // Looks one step ahead so the registered pin is low while the match stands
         else if (PWM_BITS'(time_base + 1'b1) == duty_buffer)
            next_output_level = 1'b0;
      end
      else if (match)
      begin
         event_now = 1'b1;
         case (mode_select)
            MODE_TOGGLE_CLR:
            begin
               next_output_level = !output_level;
               timer_clear       = 1'b1;
            end
            MODE_TOGGLE:       next_output_level = !output_level;
            MODE_CMP_SET:      next_output_level = 1'b1;
            MODE_CMP_CLEAR:    next_output_level = 1'b0;
            MODE_CMP_PULSE_CL:
            begin
               next_output_level  = 1'b1;
               next_pulse_pending = 1'b1;
               timer_clear        = 1'b1;
            end
            MODE_CMP_PULSE:
            begin
               next_output_level  = 1'b1;
               next_pulse_pending = 1'b1;
            end
            default:           next_output_level = output_level;
         endcase
      end
      // Pulse falls back low one cycle later
      if (pulse_pending && active && !is_pwm && !next_pulse_pending)
         next_output_level = 1'b0;
   end

   // Bus handshake: write address and data are taken together
   always_comb
   begin
      wr_go         = (wr_state == WR_IDLE) && s_axi_awvalid && s_axi_wvalid;
      rd_go         = !rd_valid && s_axi_arvalid;
      s_axi_awready = wr_go;
      s_axi_wready  = wr_go;
      s_axi_arready = rd_go;
   end

   // Register writes and capture loads
   always_comb
   begin
      next_unit_enable     = unit_enable;
      next_width_alignment = width_alignment;
      next_mode_select     = mode_select;
      next_capture_source  = capture_source;
      next_value_low_byte  = value_low_byte;
      next_value_high_byte = value_high_byte;
      next_wr_state        = wr_state;
      next_wr_resp         = wr_resp;
      if (wr_go)
      begin
         next_wr_state = WR_RESP;
         next_wr_resp  = RESP_OKAY;
         if (s_axi_wstrb[0])
         begin
            case (s_axi_awaddr)
               ADDR_UNIT_CONTROL:
               begin
                  next_unit_enable     = s_axi_wdata[CTL_ENABLE_BIT];
                  next_width_alignment = s_axi_wdata[CTL_ALIGN_BIT];
                  next_mode_select     = s_axi_wdata[3:0];
               end
               ADDR_CAPTURE_SOURCE: next_capture_source = s_axi_wdata[2:0];
               ADDR_VALUE_LOW:      next_value_low_byte = s_axi_wdata[7:0];
               ADDR_VALUE_HIGH:     next_value_high_byte = s_axi_wdata[7:0];
               default:             next_wr_resp = RESP_SLVERR;
            endcase
         end
      end
      else if ((wr_state == WR_RESP) && s_axi_bready)
         next_wr_state = WR_IDLE;
      // Capture wins over a same-cycle software write
      if (cap_event)
      begin
         next_value_low_byte  = timers.sixteen_bit_timer[7:0];
         next_value_high_byte = timers.sixteen_bit_timer[15:8];
      end
   end

   // Register reads
   always_comb
   begin
      next_rd_valid = rd_valid;
      next_rd_data  = rd_data;
      next_rd_resp  = rd_resp;
      if (rd_go)
      begin
         next_rd_valid = 1'b1;
         next_rd_resp  = RESP_OKAY;
         case (s_axi_araddr)
            ADDR_UNIT_CONTROL:   next_rd_data = {24'h000000, control_view};
            ADDR_CAPTURE_SOURCE: next_rd_data = {29'h00000000, capture_source};
            ADDR_VALUE_LOW:      next_rd_data = {24'h000000, value_low_byte};
            ADDR_VALUE_HIGH:     next_rd_data = {24'h000000, value_high_byte};
            default:
            begin
               next_rd_data = 32'h00000000;
               next_rd_resp = RESP_SLVERR;
            end
         endcase
      end
      else if (rd_valid && s_axi_rready)
         next_rd_valid = 1'b0;
   end

   // Clock enable low freezes all state
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         unit_enable     <= CONTROL_RESET[CTL_ENABLE_BIT];
         width_alignment <= CONTROL_RESET[CTL_ALIGN_BIT];
         mode_select     <= CONTROL_RESET[3:0];
         capture_source  <= SOURCE_RESET;
         value_low_byte  <= VALUE_RESET;
         value_high_byte <= VALUE_RESET;
         output_level    <= 1'b0;
         pulse_pending   <= 1'b0;
         cap_prev        <= 1'b0;
         prescale        <= 4'h0;
         duty_buffer     <= '0;
         unit_event_flag <= 1'b0;
         wr_state        <= WR_IDLE;
         wr_resp         <= RESP_OKAY;
         rd_valid        <= 1'b0;
         rd_data         <= 32'h00000000;
         rd_resp         <= RESP_OKAY;
      end
      else if (clk_en)
      begin
         unit_enable     <= next_unit_enable;
         width_alignment <= next_width_alignment;
         mode_select     <= next_mode_select;
         capture_source  <= next_capture_source;
         value_low_byte  <= next_value_low_byte;
         value_high_byte <= next_value_high_byte;
         output_level    <= next_output_level;
         pulse_pending   <= next_pulse_pending;
         cap_prev        <= next_cap_prev;
         prescale        <= next_prescale;
         duty_buffer     <= next_duty_buffer;
         // Event flag pulses for every event
         unit_event_flag <= event_now;
         wr_state        <= next_wr_state;
         wr_resp         <= next_wr_resp;
         rd_valid        <= next_rd_valid;
         rd_data         <= next_rd_data;
         rd_resp         <= next_rd_resp;
      end
   end

   // Pin is an input while disabled or off
   always_comb
   begin
      pin_out            = output_level;
      pin_oe_n           = !active;
      conversion_trigger = unit_event_flag;
      s_axi_bvalid       = wr_state == WR_RESP;
      s_axi_bresp        = wr_resp;
      s_axi_rvalid       = rd_valid;
      s_axi_rdata        = rd_data;
      s_axi_rresp        = rd_resp;
   end

   sequence s_pulse_high;
      output_level && pulse_pending;
   endsequence

   a_pulse_returns_low: assert property (@(posedge mclk) disable iff (!rst_n)
      s_pulse_high ##0 (clk_en && active && !is_pwm && !match) |=> !output_level)
      else $error("pulse did not return low");

   a_toggle_on_match: assert property (@(posedge mclk) disable iff (!rst_n)
      (clk_en && match && mode_select == MODE_TOGGLE) |=> output_level != $past(output_level))
      else $error("toggle missed");

   a_set_on_match: assert property (@(posedge mclk) disable iff (!rst_n)
      (clk_en && match && mode_select == MODE_CMP_SET) |=> output_level)
      else $error("set missed");

   a_capture_loads: assert property (@(posedge mclk) disable iff (!rst_n)
      (clk_en && cap_event) |=> {value_high_byte, value_low_byte}
         == $past(timers.sixteen_bit_timer))
      else $error("capture value wrong");

   a_off_output_low: assert property (@(posedge mclk) disable iff (!rst_n)
      (clk_en && !active) |=> !output_level)
      else $error("off mode not quiet");

   a_off_pin_input: assert property (@(posedge mclk) disable iff (!rst_n)
      !active |-> pin_oe_n)
      else $error("pin driven while off");

   a_event_sets_flag: assert property (@(posedge mclk) disable iff (!rst_n)
      (clk_en && event_now) |=> unit_event_flag && conversion_trigger)
      else $error("flag not set");

   a_reserved_no_event: assert property (@(posedge mclk) disable iff (!rst_n)
      (active && mode_select >= 4'hC && mode_select != MODE_PWM) |-> !event_now)
      else $error("reserved mode acted");

   a_period_latch: assert property (@(posedge mclk) disable iff (!rst_n)
      (clk_en && is_pwm && period_end) |=> duty_buffer == $past(width_word)
         && output_level == ($past(width_word) != '0))
      else $error("period end wrong");

   a_freeze_hold: assert property (@(posedge mclk) disable iff (!rst_n)
      !clk_en |=> $stable(output_level) && $stable(duty_buffer))
      else $error("state moved while frozen");

endmodule

// ===== inc/ccpu_pkg.sv
// Package for the capture/compare/PWM unit: register map, fields, modes
package ccpu_pkg;

   // Register byte addresses on the AXI4-Lite bus
   localparam logic [3:0] ADDR_UNIT_CONTROL   = 4'h0;
   localparam logic [3:0] ADDR_CAPTURE_SOURCE = 4'h4;
   localparam logic [3:0] ADDR_VALUE_LOW      = 4'h8;
   localparam logic [3:0] ADDR_VALUE_HIGH     = 4'hC;

   // Control register fields
   localparam int CTL_ENABLE_BIT = 7;
   localparam int CTL_OUTPUT_BIT = 5;
   localparam int CTL_ALIGN_BIT  = 4;

   // Reset values
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [2:0] SOURCE_RESET  = 3'h0;
   localparam logic [7:0] VALUE_RESET   = 8'h00;

   // Mode select codes
   localparam logic [3:0] MODE_OFF          = 4'h0;
   localparam logic [3:0] MODE_TOGGLE_CLR   = 4'h1;
   localparam logic [3:0] MODE_TOGGLE       = 4'h2;
   localparam logic [3:0] MODE_CAP_BOTH     = 4'h3;
   localparam logic [3:0] MODE_CAP_FALL     = 4'h4;
   localparam logic [3:0] MODE_CAP_RISE     = 4'h5;
   localparam logic [3:0] MODE_CAP_RISE4    = 4'h6;
   localparam logic [3:0] MODE_CAP_RISE16   = 4'h7;
   localparam logic [3:0] MODE_CMP_SET      = 4'h8;
   localparam logic [3:0] MODE_CMP_CLEAR    = 4'h9;
   localparam logic [3:0] MODE_CMP_PULSE    = 4'hA;
   localparam logic [3:0] MODE_CMP_PULSE_CL = 4'hB;
   localparam logic [3:0] MODE_PWM          = 4'hF;

   localparam logic [2:0] SOURCE_RESERVED = 3'h7;
   localparam logic [3:0] PRESCALE_4_LAST  = 4'h3;
   localparam logic [3:0] PRESCALE_16_LAST = 4'hF;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Internal capture sources
   typedef struct packed {
      logic mapped_input_pin;
      logic comparator_one_output;
      logic comparator_two_output;
      logic oscillator_output;
      logic pin_change_event;
      logic logic_cell_one_out;
      logic logic_cell_two_out;
   } ccpu_sources_s;

   // Timer interface seen by the unit
   typedef struct packed {
      logic [15:0] sixteen_bit_timer;
      logic [7:0]  period_timer;
      logic [7:0]  period_register;
      logic [1:0]  time_base_low;
      logic        period_increment;
   } ccpu_timers_s;

   typedef enum logic [1:0] {
      WR_IDLE,
      WR_RESP
   } ccpu_wr_e;

endpackage

// ===== testbench/ccpu_timer_model.sv
// Timer and signal-source model facing the capture/compare/PWM unit
`timescale 1ns/1ns
module ccpu_timer_model
   import ccpu_pkg::*;
#(
   parameter logic [7:0] PERIOD = 8'h03
)
(
   // Clock and control
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       run,
   input  wire logic [6:0] src_lv,
   // From the unit
   input  wire logic       timer_clear,
   input  wire logic       period_timer_clear,
   // To the unit
   output ccpu_timers_s    timers,
   output ccpu_sources_s   sources
);
   logic [15:0] tmr;
   logic [15:0] next_tmr;
   logic [7:0]  ptmr;
   logic [7:0]  next_ptmr;
   logic [1:0]  tbl;
   logic [1:0]  next_tbl;
   logic [6:0]  src;

   // Period timer wraps on its own at the period value, as the real one does
   always_comb
   begin
      next_tmr = tmr;
      next_ptmr = ptmr;
      next_tbl = tbl;
      if (run)
      begin
         next_tmr = timer_clear ? 16'h0000 : tmr + 16'h0001;
         next_tbl = tbl + 2'h1;
         if (tbl == 2'h3)
            next_ptmr = (ptmr == PERIOD || period_timer_clear) ? 8'h00 : ptmr + 8'h01;
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tmr <= 16'h0000;
         ptmr <= 8'h00;
         tbl <= 2'h0;
         src <= 7'h00;
      end
      else
      begin
         tmr <= next_tmr;
         ptmr <= next_ptmr;
         tbl <= next_tbl;
         src <= src_lv;
      end
   end

   assign timers = '{tmr, ptmr, PERIOD, tbl, run && tbl == 2'h3};
   assign sources = ccpu_sources_s'(src);
endmodule

// ===== testbench/testbench.sv
// Self-checking bench for the capture/compare/PWM unit
`timescale 1ns/1ns
module testbench;
   import ccpu_pkg::*;
   logic          mclk = 1'b0;
   logic          rst_n = 1'b0;
   logic          clk_en = 1'b1;
   logic          run = 1'b1;
   logic [6:0]    src_lv = 7'h00;
   logic [3:0]    awaddr = 4'h0;
   logic [3:0]    araddr = 4'h0;
   logic [31:0]   wdata = 32'h0;
   logic          awvalid = 1'b0;
   logic          wvalid = 1'b0;
   logic          arvalid = 1'b0;
   logic          awready, wready, bvalid, arready, rvalid;
   logic [1:0]    bresp, rresp, rd_resp;
   logic [31:0]   rdata, rd_val;
   logic          pin_out, pin_oe_n, tclr, ptclr, flag, conv;
   ccpu_timers_s  timers;
   ccpu_sources_s sources;
   int            bad_count = 0;
   int            total_checks = 0;
   int            flags = 0;
   int            cycles = 0;
   logic [3:0]    cm [5] = '{MODE_CAP_BOTH, MODE_CAP_FALL, MODE_CAP_RISE, MODE_CAP_RISE4,
                             MODE_CAP_RISE16};
   int            ce [5] = '{32, 16, 16, 4, 1};

   ccpu_unit dut (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .sources(sources),
      .timers(timers), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .timer_clear(tclr),
      .period_timer_clear(ptclr), .unit_event_flag(flag), .conversion_trigger(conv));

   ccpu_timer_model partner (.mclk(mclk), .rst_n(rst_n), .run(run), .src_lv(src_lv),
      .timer_clear(tclr), .period_timer_clear(ptclr), .timers(timers), .sources(sources));

   always #4 mclk = ~mclk;

   // Cycle ceiling well above the expected run length of about 3k cycles
   always @(posedge mclk)
   begin
      cycles <= cycles + 1;
      if (flag === 1'b1)
         flags <= flags + 1;
      if (cycles == 50000)
      begin
         bad_count++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic axw(input logic [3:0] a, input logic [7:0] d);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do @(posedge mclk); while (!(awready === 1'b1 && wready === 1'b1));
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(posedge mclk); while (bvalid !== 1'b1);
   endtask

   task automatic axr(input logic [3:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge mclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge mclk); while (rvalid !== 1'b1);
      rd_val = rdata;
      rd_resp = rresp;
   endtask

   task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
      axr(a);
      chk(rd_val, {24'h0, exp});
   endtask

   // Leaves the unit enabled in mode off, which also restarts the prescaler
   task automatic cap(input logic [3:0] m, input logic [2:0] s, input int n, input int exp);
      int f0;
      axw(ADDR_CAPTURE_SOURCE, {5'h00, s});
      axw(ADDR_UNIT_CONTROL, {4'h8, m});
      f0 = flags;
      repeat (n)
      begin
         src_lv <= (s == 3'h7) ? 7'h7F : (7'h40 >> s);
         repeat (3) @(posedge mclk);
         src_lv <= 7'h00;
         repeat (3) @(posedge mclk);
      end
      repeat (3) @(posedge mclk);
      chk(flags - f0, exp);
      axw(ADDR_UNIT_CONTROL, 8'h80);
   endtask

   task automatic cmp(input logic [3:0] m, input logic [15:0] t);
      int n;
      n = 0;
      axw(ADDR_VALUE_LOW, t[7:0]);
      axw(ADDR_VALUE_HIGH, t[15:8]);
      axw(ADDR_UNIT_CONTROL, {4'h8, m});
      do @(posedge mclk); while (flag !== 1'b1 && ++n < 4000);
      chk(conv, 1'b1);
   endtask

   task automatic pwm(input logic [7:0] ctl, input logic [7:0] lo, input logic [7:0] hi,
                      input int exp);
      int h;
      axw(ADDR_VALUE_LOW, lo);
      axw(ADDR_VALUE_HIGH, hi);
      axw(ADDR_UNIT_CONTROL, ctl);
      repeat (40) @(posedge mclk);
      h = 0;
      repeat (16)
      begin
         @(posedge mclk);
         if (pin_out === 1'b1)
            h++;
      end
      chk(h, exp);
   endtask

   initial
   begin
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      rchk(ADDR_UNIT_CONTROL, 8'h00);
      rchk(ADDR_CAPTURE_SOURCE, 8'h00);
      chk(pin_oe_n, 1'b1);
      axw(ADDR_UNIT_CONTROL, 8'h6C);
      rchk(ADDR_UNIT_CONTROL, 8'h0C);
      chk(pin_oe_n, 1'b1);
      axr(4'h2);
      chk({30'h0, rd_resp}, {30'h0, RESP_SLVERR});
      $display("test registers done");
      cmp(MODE_CMP_SET, 16'h0200);
      chk(pin_out, 1'b1);
      rchk(ADDR_UNIT_CONTROL, 8'hA8);
      chk(pin_oe_n, 1'b0);
      cmp(MODE_CMP_CLEAR, 16'h0300);
      chk(pin_out, 1'b0);
      cmp(MODE_TOGGLE, 16'h0400);
      chk(pin_out, 1'b1);
      cmp(MODE_CMP_PULSE, 16'h0500);
      chk(timers.sixteen_bit_timer, 16'h0501);
      @(posedge mclk);
      chk(pin_out, 1'b0);
      cmp(MODE_TOGGLE_CLR, 16'h0600);
      chk({pin_out, timers.sixteen_bit_timer}, 17'h10000);
      cmp(MODE_CMP_PULSE_CL, 16'h0040);
      chk({pin_out, timers.sixteen_bit_timer}, 17'h10000);
      $display("test compare done");
      run <= 1'b0;
      for (int i = 0; i < 5; i++)
         cap(cm[i], 3'h0, 16, ce[i]);
      for (int i = 1; i < 7; i++)
         cap(MODE_CAP_RISE, i[2:0], 1, 1);
      cap(MODE_CAP_RISE, SOURCE_RESERVED, 2, 0);
      for (int i = 12; i < 15; i++)
         cap(i[3:0], 3'h0, 2, 0);
      rchk(ADDR_VALUE_LOW, timers.sixteen_bit_timer[7:0]);
      rchk(ADDR_VALUE_HIGH, timers.sixteen_bit_timer[15:8]);
      $display("test capture done");
      run <= 1'b1;
      pwm(8'h8F, 8'h06, 8'h00, 6);
      pwm(8'h8F, 8'h05, 8'hFC, 5);
      pwm(8'h9F, 8'h40, 8'h02, 9);
      pwm(8'h9F, 8'h3F, 8'h01, 4);
      clk_en <= 1'b0;
      run <= 1'b0;
      repeat (2) @(posedge mclk);
      rd_val = {31'h0, pin_out};
      repeat (20) @(posedge mclk);
      chk({31'h0, pin_out}, rd_val);
      clk_en <= 1'b1;
      run <= 1'b1;
      pwm(8'h8F, 8'h00, 8'h00, 0);
      $display("test pwm done");
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      chk({pin_oe_n, pin_out}, 2'b10);
      rst_n <= 1'b1;
      @(posedge mclk);
      rchk(ADDR_UNIT_CONTROL, 8'h00);
      $display("test reset done");
      end_sim();
   end
endmodule
